/* inc/reading_average_filter_pkg.sv */
// Overview of operation
// - average += (reading - average) / weight
// - weight 1..99, reset value 10
// - weight register reads integer denominator
// - one weight kept per measurement function
// - filter switched by key and bus
// - key press toggles filter; lamp shows it
// - trigger blinks lamp three time constants
// - continuous out-of-window reading blinks one constant
// - out-of-window reading passes, averaging restarts
// - window 10000/1000/100/10 counts by resolution
// - internal filter bus-only, on after reset
// - internal filter acts at 5.5/6.5 digits only
// - lamp reflects front filter only
// - one-shot withholds output three time constants
// - both filters: constant is weight sum
// - internal filter bypasses on narrower window
`default_nettype none
package reading_average_filter_pkg;
   // -----------------------------------------------------------------
   // register map
   // -----------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_WEIGHT = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_AVG = 8'h0C;
   // control field positions
   localparam int CTRL_FRONT_BIT = 0;
   localparam int CTRL_INT_BIT = 1;
   localparam int CTRL_ONESHOT_BIT = 2;
   localparam int CTRL_RES_LSB = 4;
   localparam int CTRL_FUNC_LSB = 8;
   localparam int FUNC_W = 3;
   // status field positions
   localparam int STAT_LED_BIT = 0;
   localparam int STAT_BLINK_BIT = 1;
   localparam int STAT_HOLD_BIT = 2;
   // -----------------------------------------------------------------
   // filter constants
   // -----------------------------------------------------------------
   localparam logic [6:0] WEIGHT_MIN = 7'h01;
   localparam logic [6:0] WEIGHT_MAX = 7'h63;
   localparam logic [6:0] WEIGHT_RESET = 7'h0A;
   localparam logic [6:0] INT_WEIGHT_RESET = 7'h0A;
   localparam int SETTLE_TC = 3;
   localparam logic INT_EN_RESET = 1'b1;
   // display resolution codes
   typedef enum logic [1:0] {
      RES_3D5 = 2'b00,
      RES_4D5 = 2'b01,
      RES_5D5 = 2'b10,
      RES_6D5 = 2'b11
   } res_e;
   // front filter windows in counts
   localparam logic [31:0] FRONT_WIN_6D5 = 32'h0000_2710;
   localparam logic [31:0] FRONT_WIN_5D5 = 32'h0000_03E8;
   localparam logic [31:0] FRONT_WIN_4D5 = 32'h0000_0064;
   localparam logic [31:0] FRONT_WIN_3D5 = 32'h0000_000A;
   // internal filter windows, far narrower
   localparam logic [31:0] INT_WIN_6D5 = 32'h0000_0064;
   localparam logic [31:0] INT_WIN_5D5 = 32'h0000_000A;
endpackage
`default_nettype wire

/* verilog/avg_stage.sv */
`default_nettype none
module avg_stage
   import reading_average_filter_pkg::*;
#(
   parameter int RW = 24
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic in_valid,
   input wire logic signed [RW-1:0] in_data,
   input wire logic active,
   input wire logic restart,
   input wire logic [6:0] weight,
   input wire logic [31:0] window,
   output logic out_valid,
   output logic signed [RW-1:0] out_data,
   output logic jump
);
   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   typedef struct packed {
      logic primed; // average holds a seed
      logic valid; // output strobe
      logic jump; // last reading left window
      logic signed [RW-1:0] avg; // running average
   } stage_s;
   stage_s st, next_st;
   logic signed [RW:0] diff; // reading minus average
   logic [RW:0] mag; // absolute difference
   logic signed [RW:0] step; // weighted correction
   logic signed [RW:0] wdiv; // weight as divisor

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb begin
      next_st = st;
      diff = (RW+1)'(in_data) - (RW+1)'(st.avg);
      mag = diff[RW] ? $unsigned(-diff) : $unsigned(diff);
      wdiv = $signed({{(RW-6){1'b0}}, weight});
      step = diff / wdiv;
      next_st.valid = 1'b0;
      next_st.jump = 1'b0;
      if (restart) begin
         next_st.primed = 1'b0;
      end
      if (in_valid) begin
         next_st.valid = 1'b1;
         if (!active) begin
            // pass through, reseed when enabled
            next_st.avg = in_data;
            next_st.primed = 1'b0;
         end else if (!st.primed || restart) begin
            next_st.avg = in_data;
            next_st.primed = 1'b1;
         end else if (32'(mag) > window) begin
            next_st.avg = in_data;
            next_st.jump = 1'b1;
         end else begin
            next_st.avg = RW'(st.avg + step);
         end
      end
   end

   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign out_valid = st.valid;
   assign out_data = st.avg;
   assign jump = st.jump;

   property p_bypass;
      @(posedge pclk) disable iff (!presetn)
      ce && in_valid && active && st.primed && !restart && 32'(mag) > window
      |=> jump && out_data == $past(in_data);
   endproperty
   a_bypass: assert property (p_bypass) else $error("window bypass failed");

   property p_update;
      @(posedge pclk) disable iff (!presetn)
      ce && in_valid && active && st.primed && !restart && 32'(mag) <= window
      |=> !jump && out_data == RW'($past(st.avg) + $past(step));
   endproperty
   a_update: assert property (p_update) else $error("average update wrong");
endmodule // avg_stage
`default_nettype wire

/* verilog/reading_average_filter.sv */
`default_nettype none
module reading_average_filter
   import reading_average_filter_pkg::*;
#(
   parameter int RW = 24,
   parameter int NUM_FUNC = 5,
   parameter logic [6:0] INT_WEIGHT = INT_WEIGHT_RESET
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic filter_key,
   input wire logic trigger,
   input wire logic rd_valid,
   input wire logic signed [RW-1:0] rd_data,
   output logic out_valid,
   output logic signed [RW-1:0] out_data,
   output logic filter_led,
   output logic filter_blink
);
   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   typedef struct packed {
      logic front_en; // front filter on
      logic int_en; // internal filter on
      logic one_shot; // one-shot trigger mode
      logic [1:0] res; // display resolution
      logic [FUNC_W-1:0] func; // measurement function
      logic [NUM_FUNC-1:0][6:0] weights; // weight per function
      logic restart; // reseed pulse to stages
      logic [8:0] blink_cnt; // readings left to blink
      logic [9:0] hold_cnt; // readings left to settle
      logic out_valid; // output strobe
      logic signed [RW-1:0] out_data; // released reading
      logic signed [RW-1:0] disp; // displayed_average
      logic [31:0] prdata; // read data
      logic pslverr; // unmapped access
   } top_s;
   top_s st, next_st;

   logic setup; // apb setup cycle
   logic wr; // apb write taken
   logic mapped; // address hits a register
   logic [6:0] wf; // front weight of current function
   logic int_act; // internal filter acting
   logic [31:0] win_front; // front window
   logic [31:0] win_int; // internal window
   logic i_valid; // internal stage output
   logic signed [RW-1:0] i_data;
   logic f_valid; // front stage output
   logic signed [RW-1:0] f_data;
   logic f_jump; // front reading left window
   logic [8:0] blink_load; // three front constants
   logic [9:0] hold_load; // three summed constants
   logic release_ok; // reading may leave

   // -----------------------------------------------------------------
   // decode and selection
   // -----------------------------------------------------------------
   always_comb begin
      setup = psel && !penable;
      wr = psel && penable && pwrite && ce;
      mapped = 1'b0;
      if (paddr == ADDR_CTRL) begin
         mapped = 1'b1;
      end else if (paddr == ADDR_WEIGHT) begin
         mapped = 1'b1;
      end else if (paddr == ADDR_STATUS) begin
         mapped = 1'b1;
      end else if (paddr == ADDR_AVG) begin
         mapped = 1'b1;
      end
      // weight of the selected function only
      wf = (32'(st.func) < NUM_FUNC) ? st.weights[st.func] : WEIGHT_RESET;
      int_act = st.int_en && (st.res == RES_5D5 || st.res == RES_6D5);
      // window widths per resolution
      case (res_e'(st.res))
         RES_6D5: begin
            win_front = FRONT_WIN_6D5;
            win_int = INT_WIN_6D5;
         end
         RES_5D5: begin
            win_front = FRONT_WIN_5D5;
            win_int = INT_WIN_5D5;
         end
         RES_4D5: begin
            win_front = FRONT_WIN_4D5;
            win_int = INT_WIN_5D5;
         end
         default: begin
            win_front = FRONT_WIN_3D5;
            win_int = INT_WIN_5D5;
         end
      endcase
      blink_load = 9'(wf) * 9'(SETTLE_TC);
      hold_load = ((st.front_en ? 10'(wf) : 10'h000)
                  + (int_act ? 10'(INT_WEIGHT) : 10'h000))
                  * 10'(SETTLE_TC);
      release_ok = !st.one_shot || st.hold_cnt <= 10'h001;
   end

   // -----------------------------------------------------------------
   // filter chain: internal stage, then front stage
   // -----------------------------------------------------------------
   avg_stage #(.RW(RW)) u_int (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .in_valid(rd_valid),
      .in_data(rd_data),
      .active(int_act),
      .restart(st.restart),
      .weight(INT_WEIGHT),
      .window(win_int),
      .out_valid(i_valid),
      .out_data(i_data),
      .jump()
   );

   avg_stage #(.RW(RW)) u_front (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .in_valid(i_valid),
      .in_data(i_data),
      .active(st.front_en),
      .restart(st.restart),
      .weight(wf),
      .window(win_front),
      .out_valid(f_valid),
      .out_data(f_data),
      .jump(f_jump)
   );

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.out_valid = 1'b0;
      // key toggles, bus write below overrides
      if (filter_key) begin
         next_st.front_en = !st.front_en;
      end
      if (wr && paddr == ADDR_CTRL) begin
         next_st.front_en = pwdata[CTRL_FRONT_BIT];
         next_st.int_en = pwdata[CTRL_INT_BIT];
         next_st.one_shot = pwdata[CTRL_ONESHOT_BIT];
         next_st.res = pwdata[CTRL_RES_LSB +: 2];
         next_st.func = pwdata[CTRL_FUNC_LSB +: FUNC_W];
      end else if (wr && paddr == ADDR_WEIGHT) begin
         // out-of-range values leave the weight alone
         if (pwdata <= 32'(WEIGHT_MAX) && pwdata >= 32'(WEIGHT_MIN)
             && 32'(st.func) < NUM_FUNC) begin
            next_st.weights[st.func] = pwdata[6:0];
         end
      end
      // a change of front enable, internal enable, resolution or function reseeds both averages
      next_st.restart = next_st.front_en != st.front_en
                        || next_st.int_en != st.int_en
                        || next_st.res != st.res
                        || next_st.func != st.func;
      // blink and settle counters
      if (trigger) begin
         next_st.blink_cnt = st.front_en ? blink_load : 9'h000;
         next_st.hold_cnt = hold_load;
      end else if (f_valid) begin
         if (f_jump && !st.one_shot && st.front_en) begin
            next_st.blink_cnt = 9'(wf);
         end else if (st.blink_cnt != 9'h000) begin
            next_st.blink_cnt = st.blink_cnt - 9'h001;
         end
         if (st.hold_cnt != 10'h000) begin
            next_st.hold_cnt = st.hold_cnt - 10'h001;
         end
      end
      // release readings, holding them while settling in one-shot mode
      if (f_valid) begin
         next_st.disp = f_data;
         if (release_ok) begin
            next_st.out_valid = 1'b1;
            next_st.out_data = f_data;
         end
      end
      // read data captured in the setup cycle
      if (setup) begin
         next_st.pslverr = !mapped;
         next_st.prdata = 32'h0000_0000;
         if (paddr == ADDR_CTRL) begin
            next_st.prdata[CTRL_FRONT_BIT] = st.front_en;
            next_st.prdata[CTRL_INT_BIT] = st.int_en;
            next_st.prdata[CTRL_ONESHOT_BIT] = st.one_shot;
            next_st.prdata[CTRL_RES_LSB +: 2] = st.res;
            next_st.prdata[CTRL_FUNC_LSB +: FUNC_W] = st.func;
         end else if (paddr == ADDR_WEIGHT) begin
            next_st.prdata[6:0] = wf;
         end else if (paddr == ADDR_STATUS) begin
            next_st.prdata[STAT_LED_BIT] = st.front_en;
            next_st.prdata[STAT_BLINK_BIT] = filter_blink;
            next_st.prdata[STAT_HOLD_BIT] = st.hold_cnt != 10'h000;
         end else if (paddr == ADDR_AVG) begin
            next_st.prdata = 32'(st.disp);
         end
      end
   end

   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
         st.int_en <= INT_EN_RESET;
         for (int i = 0; i < NUM_FUNC; i++) begin
            st.weights[i] <= WEIGHT_RESET;
         end
      end else if (ce) begin
         st <= next_st;
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   assign pready = ce;
   assign prdata = st.prdata;
   assign pslverr = st.pslverr;
   assign out_valid = st.out_valid;
   assign out_data = st.out_data;
   assign filter_led = st.front_en;
   assign filter_blink = st.front_en && st.blink_cnt != 9'h000;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   property p_key;
      @(posedge pclk) disable iff (!presetn)
      ce && filter_key && !(wr && paddr == ADDR_CTRL)
      |=> filter_led != $past(filter_led);
   endproperty
   a_key: assert property (p_key) else $error("key did not toggle");

   // lamp moves only when the front filter state is commanded to move
   property p_lamp;
      @(posedge pclk) disable iff (!presetn)
      ce && !filter_key
      && !(wr && paddr == ADDR_CTRL && pwdata[CTRL_FRONT_BIT] != filter_led)
      |=> $stable(filter_led) && (filter_led || !filter_blink);
   endproperty
   a_lamp: assert property (p_lamp) else $error("lamp lit with filter off");

   property p_blink;
      @(posedge pclk) disable iff (!presetn)
      ce && trigger && st.front_en |=> st.blink_cnt == 9'($past(wf)) * 9'd3;
   endproperty
   a_blink: assert property (p_blink) else $error("blink length wrong");

   property p_win_blink;
      @(posedge pclk) disable iff (!presetn)
      ce && !trigger && f_valid && f_jump && !st.one_shot && st.front_en
      |=> st.blink_cnt == 9'($past(wf));
   endproperty
   a_win_blink: assert property (p_win_blink) else $error("window blink wrong");

   property p_settle;
      @(posedge pclk) disable iff (!presetn)
      ce && trigger && st.front_en && int_act
      |=> st.hold_cnt == (10'($past(wf)) + 10'(INT_WEIGHT)) * 10'd3;
   endproperty
   a_settle: assert property (p_settle) else $error("settle count wrong");

   property p_withhold;
      @(posedge pclk) disable iff (!presetn)
      ce && st.one_shot && st.hold_cnt > 10'h001 |=> !out_valid;
   endproperty
   a_withhold: assert property (p_withhold) else $error("reading left early");

   property p_weight;
      @(posedge pclk) disable iff (!presetn)
      wr && paddr == ADDR_WEIGHT && pwdata > 32'd99 |=> wf == $past(wf);
   endproperty
   a_weight: assert property (p_weight) else $error("weight range broken");

   property p_int_pass;
      @(posedge pclk) disable iff (!presetn)
      ce && rd_valid && (st.res == RES_3D5 || st.res == RES_4D5)
      |=> i_valid && i_data == $past(rd_data);
   endproperty
   a_int_pass: assert property (p_int_pass) else $error("internal filter at low res");

   property p_reseed;
      @(posedge pclk) disable iff (!presetn)
      ce && wr && paddr == ADDR_CTRL && pwdata[CTRL_FUNC_LSB +: FUNC_W] != st.func
      |=> st.restart;
   endproperty
   a_reseed: assert property (p_reseed) else $error("no reseed on change");
endmodule // reading_average_filter
`default_nettype wire

/* tb/reading_source.sv */
`default_nettype none
// conversion path model: hands one reading at a time to the filter
module reading_source #(
   parameter int RW = 24
) (
   input wire logic pclk,
   output logic rd_valid,
   output logic signed [RW-1:0] rd_data
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle at time zero
   initial begin
      rd_valid = 1'b0;
      rd_data = '0;
   end

   // -----------------------------------------------------------------
   // one reading strobe
   // -----------------------------------------------------------------
   // gap gives a slow converter; the data line is scrambled once released
   // so that a design that samples it late never sees the old value
   task automatic send(input logic signed [RW-1:0] v, input int gap);
      repeat (gap) @(posedge pclk);
      @(posedge pclk);
      rd_valid <= 1'b1;
      rd_data <= v;
      @(posedge pclk);
      rd_valid <= 1'b0;
      rd_data <= ~v;
   endtask
endmodule // reading_source
`default_nettype wire

/* tb/reading_average_filter_test.sv */
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin bad_count++; \
   $display("MISMATCH at %0t: got %h expected %h", $time, got, exp); end end
// self-checking bench for the reading filter
module reading_average_filter_test import reading_average_filter_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   logic pclk = 1'b0; // bench clock
   logic presetn, ce, psel, penable, pwrite, filter_key, trigger;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic pready, pslverr, rd_valid, out_valid, filter_led, filter_blink;
   logic signed [23:0] rd_data, out_data;
   logic signed [23:0] exp_q[$]; // expected filter outputs, oldest first
   logic signed [23:0] exp_now; // note taken off the queue
   logic [31:0] rdat; // last bus read data
   logic rerr; // last bus error flag
   int bad_count, n_tests, avg, k, r, v;
   int ctl[4] = '{32'h01, 32'h11, 32'h21, 32'h31}; // front on at 3.5d, 4.5d, 5.5d, 6.5d
   int wins[4] = '{10, 100, 1000, 10000}; // matching front windows

   reading_average_filter #(.RW(24), .NUM_FUNC(5), .INT_WEIGHT(INT_WEIGHT_RESET)) uut (
      .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .filter_key(filter_key), .trigger(trigger),
      .rd_valid(rd_valid), .rd_data(rd_data), .out_valid(out_valid),
      .out_data(out_data), .filter_led(filter_led), .filter_blink(filter_blink)
   );

   reading_source #(.RW(24)) src (.pclk(pclk), .rd_valid(rd_valid), .rd_data(rd_data));

   // -----------------------------------------------------------------
   // clock, time-zero values, watchdog
   // -----------------------------------------------------------------
   always #10 pclk = ~pclk;
   // a hang counts as a failure
   initial begin
      repeat (20000) @(posedge pclk);
      bad_count++;
      print_verdict();
   end

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   task automatic print_verdict();
      if (bad_count == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // one bus transfer: setup, access held until pready at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      `CHK(pready, 1'b1)
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(rdat, e)
   endtask
   // one-cycle pulse on the key (0) or trigger (1)
   task automatic pulse(input int which);
      @(posedge pclk);
      if (which == 0) filter_key <= 1'b1;
      else trigger <= 1'b1;
      @(posedge pclk);
      filter_key <= 1'b0;
      trigger <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask
   // send a reading and note the output it must give
   task automatic feed(input int rv, input int ev);
      exp_q.push_back(ev[23:0]);
      src.send(rv[23:0], $urandom_range(0, 2));
   endtask
   // wait for all noted outputs, bounded
   task automatic drain();
      int n;
      n = 0;
      while (exp_q.size() != 0 && n < 200) begin
         @(posedge pclk);
         n++;
      end
      `CHK(exp_q.size(), 0)
      repeat (3) @(posedge pclk);
   endtask

   // -----------------------------------------------------------------
   // output watcher
   // -----------------------------------------------------------------
   always @(posedge pclk) begin
      if (out_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            `CHK(out_valid, 1'b0)
         end else begin
            exp_now = exp_q.pop_front();
            `CHK(out_data, exp_now)
         end
      end
   end

   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial begin
      presetn = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      filter_key = 1'b0;
      trigger = 1'b0;
      void'($urandom(32'h2718));
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      `CHK(filter_led, 1'b0)
      rd_chk(ADDR_CTRL, 32'h2);
      rd_chk(ADDR_WEIGHT, 32'hA);
      rd_chk(ADDR_STATUS, 32'h0);
      apb(1'b0, 8'h10, 32'h0);
      `CHK({rerr, rdat}, 33'h1_0000_0000)
      // weight per function, out-of-range writes ignored
      apb(1'b1, ADDR_CTRL, 32'h102);
      apb(1'b1, ADDR_WEIGHT, 32'h14);
      apb(1'b1, ADDR_CTRL, 32'h002);
      apb(1'b1, ADDR_WEIGHT, 32'h5);
      apb(1'b1, ADDR_WEIGHT, 32'h0);
      apb(1'b1, ADDR_WEIGHT, 32'h64);
      rd_chk(ADDR_WEIGHT, 32'h5);
      apb(1'b1, ADDR_CTRL, 32'h102);
      rd_chk(ADDR_WEIGHT, 32'h14);
      apb(1'b1, ADDR_CTRL, 32'h002);
      rd_chk(ADDR_WEIGHT, 32'h5);
      // key toggles, bus clears
      pulse(0);
      `CHK(filter_led, 1'b1)
      pulse(0);
      `CHK(filter_led, 1'b0)
      pulse(0);
      `CHK(filter_led, 1'b1)
      apb(1'b1, ADDR_CTRL, 32'h002);
      @(posedge pclk);
      `CHK(filter_led, 1'b0)
      // frozen clock enable stalls the bus and ignores the key
      ce <= 1'b0;
      pulse(0);
      `CHK({pready, filter_led}, 2'b00)
      ce <= 1'b1;
      // internal filter idle at 3.5d
      repeat (4) begin
         v = int'($urandom_range(0, 200000)) - 100000;
         feed(v, v);
      end
      drain();
      // internal filter at 6.5d, then its narrower window at 5.5d
      apb(1'b1, ADDR_CTRL, 32'h032);
      avg = int'($urandom_range(0, 200000)) - 100000;
      feed(avg, avg);
      feed(avg + 50, avg + 5);
      avg = avg + 5;
      feed(avg + 600, avg + 600);
      apb(1'b1, ADDR_CTRL, 32'h022);
      feed(avg, avg);
      feed(avg + 50, avg + 50);
      drain();
      // front filter per resolution, weight 5
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, ADDR_CTRL, ctl[i]);
         avg = int'($urandom_range(0, 200000)) - 100000;
         feed(avg, avg);
         repeat (3) begin
            k = $urandom_range(1, wins[i] / 5 - 1);
            if ($urandom_range(0, 1) == 1) k = -k;
            feed(avg + 5 * k, avg + k);
            avg = avg + k;
         end
         r = avg + 2 * wins[i] + 7;
         feed(r, r);
         feed(r + 5, r + 1);
         drain();
      end
      // trigger blink for three constants at weight 2
      v = 1000;
      apb(1'b1, ADDR_WEIGHT, 32'h2);
      apb(1'b1, ADDR_CTRL, 32'h001);
      feed(v, v);
      drain();
      pulse(1);
      repeat (5) feed(v, v);
      drain();
      `CHK(filter_blink, 1'b1)
      feed(v, v);
      drain();
      `CHK(filter_blink, 1'b0)
      // out-of-window step blinks one constant
      feed(v + 50, v + 50);
      drain();
      `CHK(filter_blink, 1'b1)
      repeat (2) feed(v + 50, v + 50);
      drain();
      `CHK(filter_blink, 1'b0)
      // one-shot: 3 * (2 + 10) - 1 readings held, the next one released
      apb(1'b1, ADDR_CTRL, 32'h037);
      pulse(1);
      repeat (35) src.send(v[23:0], 0);
      repeat (10) @(posedge pclk);
      feed(v, v);
      drain();
      `CHK(filter_led, 1'b1)
      print_verdict();
   end
endmodule // reading_average_filter_test
`undef CHK
`default_nettype wire
